// *** rtl/port_steer_pkg.sv ***
/*
 Package for the port A and pin steering block: register indices,
 field positions, reset values and the packed carriers for pin groups.
 Assumes a 32-bit classic Wishbone slave with word-aligned registers.
*/
package port_steer_pkg;

   // Register byte addresses, one aligned word each.
   localparam logic [7:0] ADDR_PIN_VALUE = 8'h00;
   localparam logic [7:0] ADDR_DIRECTION = 8'h04;
   localparam logic [7:0] ADDR_LATCH = 8'h08;
   localparam logic [7:0] ADDR_ANALOG = 8'h0C;
   localparam logic [7:0] ADDR_THRESHOLD = 8'h10;
   localparam logic [7:0] ADDR_STEER0 = 8'h14;
   localparam logic [7:0] ADDR_STEER1 = 8'h18;

   // Reset values of the software registers.
   localparam logic [5:0] DIRECTION_RST = 6'h3F;
   localparam logic [5:0] LATCH_RST = 6'h00;
   localparam logic [5:0] ANALOG_RST = 6'h17;
   localparam logic [5:0] THRESHOLD_RST = 6'h04;
   localparam logic [7:0] STEER0_RST = 8'h00;
   localparam logic [7:0] STEER1_RST = 8'h00;

   // Implemented bit masks.
   localparam logic [5:0] ANALOG_MASK = 6'h17;
   localparam logic [5:0] LATCH_MASK = 6'h37;
   localparam logic [7:0] STEER0_MASK_14 = 8'hEC;
   localparam logic [7:0] STEER0_MASK_20 = 8'h8C;
   localparam logic [7:0] STEER1_MASK_14 = 8'h0F;
   localparam logic [7:0] STEER1_MASK_20 = 8'h3F;

   // Field positions.
   localparam int INPUT_ONLY_BIT = 3;
   localparam int SERIAL_RX_SEL_BIT = 7;
   localparam int SERIAL_OUT1_SEL_BIT = 6;
   localparam int SLAVE_SEL1_SEL_BIT = 5;
   localparam int TIMER_GATE_SEL_BIT = 3;
   localparam int SERIAL_TX_SEL_BIT = 2;
   localparam int SERIAL_OUT2_SEL_BIT = 5;
   localparam int SLAVE_SEL2_SEL_BIT = 4;
   localparam int PWM1_D_SEL_BIT = 3;
   localparam int PWM1_C_SEL_BIT = 2;
   localparam int PWM2_B_SEL_BIT = 1;
   localparam int CAPTURE2_SEL_BIT = 0;

   // One 8-bit pin group: level out and output enable (low drives).
   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe_n;
   } pin_drive_t;

   // Peripheral outputs and their direction overrides (1 means the
   // peripheral takes the pin as an output).
   typedef struct packed {
      logic serial_rx_out;
      logic serial_rx_own;
      logic serial_tx_out;
      logic serial_tx_own;
      logic first_serial_data_out;
      logic first_serial_data_out_own;
      logic second_serial_data_out;
      logic second_serial_data_out_own;
      logic pwm1_c;
      logic pwm1_c_own;
      logic pwm1_d;
      logic pwm1_d_own;
      logic pwm2_b;
      logic pwm2_b_own;
      logic capture2;
      logic capture2_own;
   } periph_out_t;

   // Peripheral inputs gathered from the steered pins.
   typedef struct packed {
      logic serial_rx_in;
      logic serial_tx_in;
      logic slave_sel1;
      logic slave_sel2;
      logic timer_gate;
      logic capture2_in;
   } periph_in_t;

endpackage

// *** rtl/port_a_with_pin_steering.sv ***
/*
 Port A general-purpose I/O with pin steering for the serial, timer gate
 and PWM functions, reached over a 32-bit classic Wishbone slave.
 Assumes pin levels arrive already conditioned by both threshold
 buffers and synchronous to clk_in; ports B and C pins stay outside and
 are modelled only by the override and input paths this block produces.
*/
`timescale 1ns/100ps
module port_a_with_pin_steering
   import port_steer_pkg::*;
#(
   parameter bit TWENTY_PIN = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [5:0] pa_schmitt_in,
   input wire logic [5:0] pa_ttl_in,
   input wire logic [7:0] pb_in,
   input wire logic [7:0] pc_in,
   input wire periph_out_t periph_in,
   output pin_drive_t pa_out,
   output pin_drive_t pb_ovr_out,
   output pin_drive_t pc_ovr_out,
   output periph_in_t periph_out,
   output logic [5:0] port_a_threshold_out,
   output logic [5:0] port_a_analog_select_out
);

   localparam logic [7:0] STEER0_MASK = TWENTY_PIN ? STEER0_MASK_20 : STEER0_MASK_14;
   localparam logic [7:0] STEER1_MASK = TWENTY_PIN ? STEER1_MASK_20 : STEER1_MASK_14;

   logic [5:0] port_a_direction_r;
   logic [5:0] port_a_output_latch_r;
   logic [5:0] port_a_analog_select_r;
   logic [5:0] port_a_input_threshold_r;
   logic [7:0] pin_steering_control_0_r;
   logic [7:0] pin_steering_control_1_r;
   logic [5:0] pa_level;
   logic [5:0] port_a_pin_value;
   logic [5:0] ovr_en;
   logic [5:0] ovr_val;
   logic [31:0] rd_nxt;
   logic req;
   logic wr_go;

   // Masked byte-lane merge used by the two steering register writes.
   function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
                                        input logic [7:0] mask);
      merge = (old & ~mask) | (wr & mask);
   endfunction

   // Only the low byte lane carries register data.
   assign req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   assign wr_go = req & wb_we_in & wb_sel_in[0];

   // Each pin's input buffer follows its threshold bit; analog reads zero.
   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_in
         assign pa_level[gi] = port_a_input_threshold_r[gi] ? pa_schmitt_in[gi] : pa_ttl_in[gi];
         assign port_a_pin_value[gi] = pa_level[gi] & ~port_a_analog_select_r[gi];
      end
   endgenerate

   // Ack one cycle after the request, dropped the cycle after.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_ack_out <= 1'b0;
      end else begin
         wb_ack_out <= req;
      end
   end

   // Read data is registered; unmapped offsets read zero.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (wb_adr_in)
         ADDR_PIN_VALUE: rd_nxt[5:0] = port_a_pin_value;
         ADDR_DIRECTION: rd_nxt[5:0] = port_a_direction_r | 6'h08;
         ADDR_LATCH: rd_nxt[5:0] = port_a_output_latch_r & LATCH_MASK;
         ADDR_ANALOG: rd_nxt[5:0] = port_a_analog_select_r;
         ADDR_THRESHOLD: rd_nxt[5:0] = port_a_input_threshold_r;
         ADDR_STEER0: rd_nxt[7:0] = pin_steering_control_0_r & STEER0_MASK;
         ADDR_STEER1: rd_nxt[7:0] = pin_steering_control_1_r & STEER1_MASK;
         default: rd_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wb_dat_out <= 32'h0000_0000;
      end else if (req && !wb_we_in) begin
         wb_dat_out <= rd_nxt;
      end
   end

   // Direction register; bit three is held at one because it never drives.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_a_direction_r <= DIRECTION_RST;
      end else if (wr_go && wb_adr_in == ADDR_DIRECTION) begin
         port_a_direction_r <= wb_dat_in[5:0] | 6'h08;
      end
   end

   // Port and latch writes both land in the latch. A bus write covers the
   // whole byte, so the merge keeps no sampled pin bit; software that does
   // its own read-modify-write can still clobber a latch bit from an analog pin.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_a_output_latch_r <= LATCH_RST;
      end else if (wr_go && wb_adr_in == ADDR_PIN_VALUE) begin
         port_a_output_latch_r <= wb_dat_in[5:0] & LATCH_MASK;
      end else if (wr_go && wb_adr_in == ADDR_LATCH) begin
         port_a_output_latch_r <= wb_dat_in[5:0] & LATCH_MASK;
      end
   end

   // Analog select resets to analog on every implemented pin.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_a_analog_select_r <= ANALOG_RST;
      end else if (wr_go && wb_adr_in == ADDR_ANALOG) begin
         port_a_analog_select_r <= wb_dat_in[5:0] & ANALOG_MASK;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         port_a_input_threshold_r <= THRESHOLD_RST;
      end else if (wr_go && wb_adr_in == ADDR_THRESHOLD) begin
         port_a_input_threshold_r <= wb_dat_in[5:0];
      end
   end

   // Steering registers; bits absent on this variant stay zero.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_steering_control_0_r <= STEER0_RST;
         pin_steering_control_1_r <= STEER1_RST;
      end else if (wr_go && wb_adr_in == ADDR_STEER0) begin
         pin_steering_control_0_r <= merge(8'h00, wb_dat_in[7:0], STEER0_MASK);
      end else if (wr_go && wb_adr_in == ADDR_STEER1) begin
         pin_steering_control_1_r <= merge(8'h00, wb_dat_in[7:0], STEER1_MASK);
      end
   end

   assign port_a_threshold_out = port_a_input_threshold_r;
   assign port_a_analog_select_out = port_a_analog_select_r;

   // Steering decode: each peripheral override lands on its chosen pin;
   // the unselected pin keeps plain port behaviour. Directions untouched.
   logic s_rx, s_first_serial_data_out, s_ss1, s_tg, s_tx, s_second_serial_data_out, s_ss2, s_p1d, s_p1c, s_p2b, s_ccp2;
   assign s_rx = pin_steering_control_0_r[SERIAL_RX_SEL_BIT];
   assign s_first_serial_data_out = pin_steering_control_0_r[SERIAL_OUT1_SEL_BIT] & ~TWENTY_PIN;
   assign s_ss1 = pin_steering_control_0_r[SLAVE_SEL1_SEL_BIT] & ~TWENTY_PIN;
   assign s_tg = pin_steering_control_0_r[TIMER_GATE_SEL_BIT];
   assign s_tx = pin_steering_control_0_r[SERIAL_TX_SEL_BIT];
   assign s_second_serial_data_out = pin_steering_control_1_r[SERIAL_OUT2_SEL_BIT] & TWENTY_PIN;
   assign s_ss2 = pin_steering_control_1_r[SLAVE_SEL2_SEL_BIT] & TWENTY_PIN;
   assign s_p1d = pin_steering_control_1_r[PWM1_D_SEL_BIT];
   assign s_p1c = pin_steering_control_1_r[PWM1_C_SEL_BIT];
   assign s_p2b = pin_steering_control_1_r[PWM2_B_SEL_BIT];
   assign s_ccp2 = pin_steering_control_1_r[CAPTURE2_SEL_BIT];

   // Port A overrides; on pins 4 and 5 the serial data output listed first wins over the PWM2 B or capture leg.
   always_comb begin
      ovr_en = 6'h00;
      ovr_val = 6'h00;
      if (!TWENTY_PIN && s_tx && periph_in.serial_tx_own) begin
         ovr_en[0] = 1'b1;
         ovr_val[0] = periph_in.serial_tx_out;
      end
      if (!TWENTY_PIN && s_rx && periph_in.serial_rx_own) begin
         ovr_en[1] = 1'b1;
         ovr_val[1] = periph_in.serial_rx_out;
      end
      if (s_first_serial_data_out && periph_in.first_serial_data_out_own) begin
         ovr_en[4] = 1'b1;
         ovr_val[4] = periph_in.first_serial_data_out;
      end else if (s_p2b && periph_in.pwm2_b_own) begin
         ovr_en[4] = 1'b1;
         ovr_val[4] = periph_in.pwm2_b;
      end
      if (s_second_serial_data_out && periph_in.second_serial_data_out_own) begin
         ovr_en[5] = 1'b1;
         ovr_val[5] = periph_in.second_serial_data_out;
      end else if (s_ccp2 && periph_in.capture2_own) begin
         ovr_en[5] = 1'b1;
         ovr_val[5] = periph_in.capture2;
      end
      ovr_en[INPUT_ONLY_BIT] = 1'b0;
   end

   // Pin drivers: the direction bit decides the enable, analog or not,
   // unless a steered peripheral claims the pin. That claim travels with
   // the pin choice, so the unselected pin keeps plain port behaviour.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pa_out <= '{level: 8'h00, oe_n: 8'hFF};
      end else begin
         pa_out.oe_n <= {2'b11, (port_a_direction_r & ~ovr_en) | 6'h08};
         pa_out.level <= {2'b00, (ovr_en & ovr_val) | (~ovr_en & port_a_output_latch_r)};
      end
   end

   // Overrides routed to ports B and C; an enable low means the
   // peripheral claims the pin as output there. The port's own direction
   // logic outside still decides whether the driver is on.
   logic [7:0] pb_en, pb_v, pc_en, pc_v;
   always_comb begin
      pb_en = 8'h00;
      pb_v = 8'h00;
      pc_en = 8'h00;
      pc_v = 8'h00;
      if (TWENTY_PIN) begin
         pb_en[5] = ~s_rx & periph_in.serial_rx_own;
         pb_v[5] = periph_in.serial_rx_out;
         pb_en[7] = ~s_tx & periph_in.serial_tx_own;
         pb_v[7] = periph_in.serial_tx_out;
         pc_en[5] = s_rx & periph_in.serial_rx_own;
         pc_v[5] = periph_in.serial_rx_out;
         pc_en[4] = s_tx & periph_in.serial_tx_own;
         pc_v[4] = periph_in.serial_tx_out;
         pc_en[7] = periph_in.first_serial_data_out_own;
         pc_v[7] = periph_in.first_serial_data_out;
         pc_en[1] = ~s_second_serial_data_out & periph_in.second_serial_data_out_own;
         pc_v[1] = periph_in.second_serial_data_out;
      end else begin
         pc_en[5] = ~s_rx & periph_in.serial_rx_own;
         pc_v[5] = periph_in.serial_rx_out;
         pc_en[4] = ~s_tx & periph_in.serial_tx_own;
         pc_v[4] = periph_in.serial_tx_out;
         pc_en[2] = ~s_first_serial_data_out & periph_in.first_serial_data_out_own;
         pc_v[2] = periph_in.first_serial_data_out;
      end
      if (!pc_en[2] && !s_p1d && periph_in.pwm1_d_own) begin
         pc_en[2] = 1'b1;
         pc_v[2] = periph_in.pwm1_d;
      end else if (!pc_en[2] && !s_p2b && periph_in.pwm2_b_own) begin
         pc_en[2] = 1'b1;
         pc_v[2] = periph_in.pwm2_b;
      end
      if (s_p1d && periph_in.pwm1_d_own) begin
         pc_en[0] = 1'b1;
         pc_v[0] = periph_in.pwm1_d;
      end
      if (!pc_en[1] && s_p1c && periph_in.pwm1_c_own) begin
         pc_en[1] = 1'b1;
         pc_v[1] = periph_in.pwm1_c;
      end
      if (!s_p1c && periph_in.pwm1_c_own) begin
         pc_en[3] = 1'b1;
         pc_v[3] = periph_in.pwm1_c;
      end else if (!s_ccp2 && periph_in.capture2_own) begin
         pc_en[3] = 1'b1;
         pc_v[3] = periph_in.capture2;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pb_ovr_out <= '{level: 8'h00, oe_n: 8'hFF};
         pc_ovr_out <= '{level: 8'h00, oe_n: 8'hFF};
      end else begin
         pb_ovr_out <= '{level: pb_v, oe_n: ~pb_en};
         pc_ovr_out <= '{level: pc_v, oe_n: ~pc_en};
      end
   end

   // Input steering: peripheral inputs come from the selected pin only.
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         periph_out <= '0;
      end else if (TWENTY_PIN) begin
         periph_out.serial_rx_in <= s_rx ? pc_in[5] : pb_in[5];
         periph_out.serial_tx_in <= s_tx ? pc_in[4] : pb_in[7];
         periph_out.slave_sel1 <= pc_in[6];
         periph_out.slave_sel2 <= s_ss2 ? port_a_pin_value[4] : pc_in[0];
         periph_out.timer_gate <= s_tg ? port_a_pin_value[3] : port_a_pin_value[4];
         periph_out.capture2_in <= s_ccp2 ? port_a_pin_value[5] : pc_in[3];
      end else begin
         periph_out.serial_rx_in <= s_rx ? port_a_pin_value[1] : pc_in[5];
         periph_out.serial_tx_in <= s_tx ? port_a_pin_value[0] : pc_in[4];
         periph_out.slave_sel1 <= s_ss1 ? port_a_pin_value[3] : pc_in[3];
         periph_out.slave_sel2 <= 1'b1;
         periph_out.timer_gate <= s_tg ? port_a_pin_value[3] : port_a_pin_value[4];
         periph_out.capture2_in <= s_ccp2 ? port_a_pin_value[5] : pc_in[3];
      end
   end

endmodule

// *** testbench/port_steer_checker.sv ***
/*
 Concurrent checks on the bus handshake and read paths of the port block.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module port_steer_checker
   import port_steer_pkg::*;
#(
   parameter bit TWENTY_PIN = 1'b0
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic [5:0] pa_schmitt_in,
   input wire logic [5:0] pa_ttl_in,
   input wire pin_drive_t pa_out,
   input wire logic [5:0] port_a_threshold_out,
   input wire logic [5:0] port_a_analog_select_out
);
   // A request counts as taken only while the slave is not answering yet.
   logic take;
   logic rd_take;
   logic [7:0] s0_mask;
   assign take = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign rd_take = take && !wb_we_in;
   assign s0_mask = TWENTY_PIN ? STEER0_MASK_20 : STEER0_MASK_14;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   ack_follows_take_a: assert property (take |=> wb_ack_out) else $error("ack missing");
   ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   ack_cause_a: assert property (wb_ack_out |-> $past(take)) else $error("ack without request");
   upper_zero_a: assert property (wb_dat_out[31:8] == 24'h00_0000) else $error("upper data set");
   input_only_a: assert property (pa_out.oe_n[3] && pa_out.oe_n[7:6] == 2'h3)
      else $error("input only pin driven");
   dir_bit_read_a: assert property (rd_take && wb_adr_in == ADDR_DIRECTION |=> wb_dat_out[3])
      else $error("direction bit three clear");
   // The pin read is sampled at the taking edge and shown one cycle later.
   pin_read_a: assert property (rd_take && wb_adr_in == ADDR_PIN_VALUE |=>
      wb_dat_out[5:0] == $past(((pa_schmitt_in & port_a_threshold_out) |
      (pa_ttl_in & ~port_a_threshold_out)) & ~port_a_analog_select_out))
      else $error("pin read wrong");
   steer_absent_a: assert property (rd_take && wb_adr_in == ADDR_STEER0 |=>
      (wb_dat_out[7:0] & ~s0_mask) == 8'h00) else $error("absent steering bit set");
   analog_bits_a: assert property ((port_a_analog_select_out & ~ANALOG_MASK) == 6'h00)
      else $error("unimplemented analog bit set");
   cover property (take && wb_we_in);
   cover property (rd_take && wb_adr_in == ADDR_PIN_VALUE);
   cover property (take && wb_adr_in == ADDR_STEER1);
endmodule
bind port_a_with_pin_steering port_steer_checker #(.TWENTY_PIN(TWENTY_PIN)) chk (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
   .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_out(wb_dat_out),
   .wb_ack_out(wb_ack_out), .pa_schmitt_in(pa_schmitt_in), .pa_ttl_in(pa_ttl_in),
   .pa_out(pa_out), .port_a_threshold_out(port_a_threshold_out),
   .port_a_analog_select_out(port_a_analog_select_out));

// *** testbench/pin_world.sv ***
/*
 Model of the package pins around the block: external levels and buffers.
 Assumes the bench sets the outside levels; no pull-ups are modelled.
*/
`timescale 1ns/100ps
module pin_world
   import port_steer_pkg::*;
(
   input wire pin_drive_t pa_drive_in,
   input wire pin_drive_t pc_drive_in,
   input wire logic [5:0] pa_ext_in,
   input wire logic [7:0] pc_ext_in,
   input wire logic [5:0] ttl_flip_in,
   output logic [5:0] pa_schmitt_out,
   output logic [5:0] pa_ttl_out,
   output logic [7:0] pc_pin_out
);
   // A driven pin shows the driver, a released one the outside level.
   logic [5:0] pa_pin;
   assign pa_pin = (pa_drive_in.level[5:0] & ~pa_drive_in.oe_n[5:0]) |
      (pa_ext_in & pa_drive_in.oe_n[5:0]);
   assign pc_pin_out = (pc_drive_in.level & ~pc_drive_in.oe_n) | (pc_ext_in & pc_drive_in.oe_n);
   // The buffers differ where flipped, so a wrong threshold pick shows.
   assign pa_schmitt_out = pa_pin;
   assign pa_ttl_out = pa_pin ^ ttl_flip_in;
endmodule

// *** testbench/port_a_with_pin_steering_bench.sv ***
/*
 Self-checking bench for the port A block with pin steering: a 14-pin build,
 and a 20-pin build on the same bus and pins for the steering only it has.
 Assumes the one-cycle registered ack and one-edge pin updates of the block.
*/
`timescale 1ns/100ps
`define CHECK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; \
   $display("BAD %s expected %h seen %h", nm, e, s); end end
module port_a_with_pin_steering_bench import port_steer_pkg::*;;
   typedef struct { string nm; logic [31:0] exp; int kind; } note_t;
   localparam logic [7:0] RA[6] = '{ADDR_DIRECTION, ADDR_LATCH, ADDR_ANALOG,
      ADDR_THRESHOLD, ADDR_STEER0, ADDR_STEER1};
   localparam logic [7:0] RV[6] = '{8'h3F, 8'h00, 8'h17, 8'h04, 8'h00, 8'h00};
   localparam int FN[8] = '{6, 7, 5, 2, 3, 1, 0, 4};
   localparam int SR[8] = '{0, 0, 0, 1, 1, 1, 1, 1};
   localparam int SB[8] = '{2, 7, 6, 3, 2, 1, 0, 5};
   localparam int P0[8] = '{4, 5, 2, 2, 3, 2, 3, 1};
   localparam int P1[8] = '{16, 17, 20, 0, 1, 20, 21, 21};
   logic clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, ack, probe_r = 1'b0;
   logic [7:0] adr = 8'h00, ext_pc = 8'h00, pc_pin;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic [5:0] ext_pa = 6'h00, flip = 6'h00, sch, ttl, thr_o, ana_o;
   periph_out_t pin_src = '0;
   periph_in_t pin_dst;
   pin_drive_t pa_o, pc_o;
   logic [31:0] rdat20;
   periph_in_t dst20;
   pin_drive_t pa20, pc20;
   int n_fail = 0, n_compared = 0;
   note_t notes[$];
   port_a_with_pin_steering uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc),
      .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(adr), .wb_sel_in(4'h1),
      .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack), .pa_schmitt_in(sch),
      .pa_ttl_in(ttl), .pb_in(8'h00), .pc_in(pc_pin), .periph_in(pin_src), .pa_out(pa_o),
      .pb_ovr_out(), .pc_ovr_out(pc_o), .periph_out(pin_dst),
      .port_a_threshold_out(thr_o), .port_a_analog_select_out(ana_o));
   pin_world world (.pa_drive_in(pa_o), .pc_drive_in(pc_o), .pa_ext_in(ext_pa),
      .pc_ext_in(ext_pc), .ttl_flip_in(flip), .pa_schmitt_out(sch), .pa_ttl_out(ttl),
      .pc_pin_out(pc_pin));
   // The 20-pin build answers in step with the first; port B sees the C pins.
   port_a_with_pin_steering #(.TWENTY_PIN(1'b1)) uut20 (.clk_in(clk_in),
      .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
      .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat), .wb_dat_out(rdat20),
      .wb_ack_out(), .pa_schmitt_in(sch), .pa_ttl_in(ttl), .pb_in(pc_pin), .pc_in(pc_pin),
      .periph_in(pin_src), .pa_out(pa20), .pb_ovr_out(), .pc_ovr_out(pc20),
      .periph_out(dst20), .port_a_threshold_out(), .port_a_analog_select_out());
   // The clock runs at 250 MHz.
   initial begin
      forever #2 clk_in = ~clk_in;
   end
   function automatic logic [31:0] pin_exp(input logic [7:0] oe_n, input logic [7:0] lv);
      return {16'h0000, lv & ~oe_n, oe_n};
   endfunction
   task finish_test;
      $display("Compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // One classic cycle; the request stands until ack is sampled high.
   task access(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
      input int k);
      if (!w) notes.push_back('{$sformatf("read %h", a), {24'h00_0000, e}, k});
      @(posedge clk_in);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= w;
      adr <= a;
      wdat <= {24'h00_0000, d};
      @(posedge clk_in);
      while (ack !== 1'b1) @(posedge clk_in);
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      access(1'b1, a, d, 8'h00, 0);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      access(1'b0, a, 8'h00, e, 0);
   endtask
   task rd20(input logic [7:0] a, input logic [7:0] e);
      access(1'b0, a, 8'h00, e, 4);
   endtask
   // Pins settle for a few edges before the monitor takes a look.
   task probe(input int k, input string nm, input logic [31:0] e);
      repeat (4) @(posedge clk_in);
      notes.push_back('{nm, e, k});
      probe_r <= 1'b1;
      @(posedge clk_in);
      probe_r <= 1'b0;
   endtask
   task place(input int p, input int k);
      logic [7:0] m;
      m = 8'h01 << (p % 16);
      probe(k, "a side", p >= 16 ? pin_exp(~m, m) : pin_exp(8'hFF, 8'h00));
      probe(k + 1, "c side", p < 16 ? pin_exp(~m, m) : pin_exp(8'hFF, 8'h00));
   endtask
   // Each result that shows is matched with the oldest note.
   always @(posedge clk_in) begin
      note_t n;
      logic [31:0] seen;
      if ((ack === 1'b1 && wb_we === 1'b0) || probe_r) begin
         n = notes.pop_front();
         case (n.kind)
            0: seen = rdat;
            1: seen = pin_exp(pa_o.oe_n, pa_o.level);
            2: seen = pin_exp(pc_o.oe_n, pc_o.level);
            4: seen = rdat20;
            5: seen = pin_exp(pa20.oe_n, pa20.level);
            6: seen = pin_exp(pc20.oe_n, pc20.level);
            7: seen = {26'h000_0000, dst20};
            default: seen = {26'h000_0000, pin_dst & 6'h3B};
         endcase
         `CHECK(n.nm, n.exp, seen)
      end
   end
   // A hang is cut short well after the sequence should have ended.
   initial begin
      #(8000 * 4);
      n_fail++;
      $display("BAD watchdog expected done seen hang");
      finish_test();
   end
   // Main sequence.
   initial begin
      logic [5:0] e;
      logic [7:0] c;
      logic [5:0] t;
      void'($urandom(32'ha6a6_9385));
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 6; i++) rd(RA[i], RV[i]);
      probe(1, "reset pins", pin_exp(8'hFF, 8'h00));
      e = 6'($urandom());
      ext_pa <= e;
      wr(ADDR_ANALOG, 8'h00);
      wr(ADDR_THRESHOLD, 8'h3F);
      repeat (3) begin
         t = 6'($urandom());
         wr(ADDR_DIRECTION, {2'b00, t});
         rd(ADDR_DIRECTION, {2'b00, t | 6'h08});
      end
      wr(ADDR_DIRECTION, 8'h00);
      wr(ADDR_LATCH, 8'hFF);
      rd(ADDR_LATCH, 8'h37);
      probe(1, "driven pins", pin_exp(8'hC8, 8'h37));
      rd(ADDR_PIN_VALUE, {2'b00, 6'h37 | (e & 6'h08)});
      wr(ADDR_PIN_VALUE, 8'h2A);
      rd(ADDR_LATCH, 8'h22);
      wr(ADDR_ANALOG, 8'h17);
      probe(1, "analog pins", pin_exp(8'hC8, 8'h22));
      rd(ADDR_PIN_VALUE, {2'b00, (6'h22 | (e & 6'h08)) & ~6'h17});
      wr(ADDR_ANALOG, 8'h00);
      wr(ADDR_DIRECTION, 8'h3F);
      flip <= 6'h3F;
      repeat (4) begin
         t = 6'($urandom());
         e = 6'($urandom());
         ext_pa <= e;
         wr(ADDR_THRESHOLD, {2'b00, t});
         rd(ADDR_PIN_VALUE, {2'b00, ~(e ^ t)});
      end
      flip <= 6'h00;
      wr(ADDR_THRESHOLD, 8'h3F);
      wr(ADDR_STEER0, 8'hFF);
      rd(ADDR_STEER0, 8'hEC);
      rd20(ADDR_STEER0, 8'h8C);
      wr(ADDR_STEER1, 8'hFF);
      rd(ADDR_STEER1, 8'h0F);
      rd20(ADDR_STEER1, 8'h3F);
      rd(ADDR_DIRECTION, 8'h3F);
      wr(8'h40, 8'h55);
      rd(8'h40, 8'h00);
      wr(ADDR_STEER0, 8'h00);
      wr(ADDR_STEER1, 8'h00);
      // Outputs: transmit, receive, first data out, PWM legs, capture, and
      // last the second data out, which only the 20-pin build steers.
      for (int i = 0; i < 8; i++) begin
         pin_src <= periph_out_t'(16'h0003 << (2 * FN[i]));
         wr(SR[i] ? ADDR_STEER1 : ADDR_STEER0, 8'h00);
         place(P0[i], i < 7 ? 1 : 5);
         wr(SR[i] ? ADDR_STEER1 : ADDR_STEER0, 8'h01 << SB[i]);
         place(P1[i], i < 7 ? 1 : 5);
         wr(SR[i] ? ADDR_STEER1 : ADDR_STEER0, 8'h00);
      end
      pin_src <= '0;
      e = 6'($urandom());
      c = 8'($urandom());
      ext_pa <= e;
      ext_pc <= c;
      probe(3, "inputs home", {26'h000_0000, c[5], c[4], c[3], 1'b0, e[4], c[3]});
      probe(7, "inputs home 20", {26'h000_0000, c[5], c[7], c[6], c[0], e[4], c[3]});
      wr(ADDR_STEER0, 8'hEC);
      wr(ADDR_STEER1, 8'h11);
      probe(3, "inputs moved", {26'h000_0000, e[1], e[0], e[3], 1'b0, e[3], e[5]});
      probe(7, "inputs moved 20", {26'h000_0000, c[5], c[4], c[6], e[4], e[3], e[5]});
      finish_test();
   end
endmodule
